// *** common/rsf_pkg.sv ***
package rsf_pkg;
	// core clock and base sample rates, rates in milli-hertz
	localparam longint CLK_HZ      = 64'd50000000;
	localparam longint FS_HL_MHZ   = 64'd13770000;
	localparam longint FS_J_MHZ    = 64'd14160000;
	localparam int     TICK_HL     = int'((CLK_HZ * 64'd1000) / FS_HL_MHZ);
	localparam int     TICK_J      = int'((CLK_HZ * 64'd1000) / FS_J_MHZ);
	localparam int     TICK_W      = 12;
	// host wait after power-up
	localparam int     WAIT_MS     = 1;
	localparam int     WAIT_CYC    = int'(CLK_HZ / 64'd1000) * WAIT_MS;
	// data widths, low-pass order limits and notch delay
	localparam int     ADC_W       = 24;
	localparam int     RATE_W      = 24;
	localparam int     RATE_NARROW = 16;
	localparam int     TIN_W       = 16;
	localparam int     TOUT_W      = 12;
	localparam int     FRAC        = 18;
	localparam int     ACC_W       = 48;
	localparam int     LP_MAX      = 4;
	localparam int     LP_MIN      = 2;
	localparam int     DEC_W       = 7;
	localparam int     NOTCH_D     = 7;
	localparam int     T8          = 8;
	localparam int     T10         = 10;
	localparam int     T12         = 12;
	// serial interface forms
	typedef enum logic [1:0] {
		IF_SPI4 = 2'h0,
		IF_SPI3 = 2'h1,
		IF_I2C  = 2'h2
	} rsf_if_t;
	// temperature width select
	typedef enum logic [1:0] {
		TW_8  = 2'h0,
		TW_10 = 2'h1,
		TW_12 = 2'h2
	} rsf_tw_t;
	// power-up sequencer states
	typedef enum logic [1:0] {
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10
	} rsf_st_t;
	// processing configuration
	typedef struct packed {
		logic       gradeJ;
		logic       wide24;
		logic [2:0] odrSel;
		logic       lpfEn;
		logic [1:0] lpfOrder;
		logic [3:0] lpfCut;
		logic       hpfEn;
		logic [2:0] hpfCut;
		logic       notchEn;
		rsf_tw_t    tempW;
	} rsf_cfg_t;
endpackage

// *** dv/rsf_output_filter_chain_tb.sv ***
`timescale 1ns/10ps
// self-checking bench for the output filter chain
module rsf_output_filter_chain_tb;
	import rsf_pkg::*;
	localparam int WAITC = 20;
	logic                     core_clk = 1'h0;
	logic                     sys_rst  = 1'h1;
	rsf_cfg_t                 cfg      = '0;
	logic signed [ADC_W-1:0]  adcData  = '0;
	logic signed [TIN_W-1:0]  tempData = '0;
	logic [1:0]               ifMode   = 2'h0;
	logic                     multiDevFuse = 1'h0;
	logic                     stall    = 1'h0;
	logic                     rateReady;
	logic signed [RATE_W-1:0] rateData;
	logic                     rateValid;
	logic signed [TOUT_W-1:0] tempOut;
	logic                     serialReady;
	logic                     ifModeOk;
	logic                     multiDevActive;
	int                       nMismatch = 0;
	int                       samplesChecked = 0;
	// 50 MHz clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	rsf_output_filter_chain #(.WAIT_CYCLES(WAITC), .NOTCH_DLY(NOTCH_D)) i_rsf_output_filter_chain (
		.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .adcData(adcData),
		.tempData(tempData), .ifMode(ifMode), .multiDevFuse(multiDevFuse),
		.rateReady(rateReady), .rateData(rateData), .rateValid(rateValid),
		.tempOut(tempOut), .serialReady(serialReady), .ifModeOk(ifModeOk),
		.multiDevActive(multiDevActive)
	);
	rsf_rx_model i_rsf_rx_model (
		.core_clk(core_clk), .stall(stall), .serialReady(serialReady),
		.rateData(rateData), .rateValid(rateValid), .rateReady(rateReady)
	);
	// verdict and end of run
	task automatic giveVerdict();
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// one comparison, sign extended to 32 bits
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// bounded wait until a rate word stands
	task automatic waitWord();
		int n;
		n = 0;
		while (rateValid !== 1'h1 && n < 8000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 8000) begin
			chk("word timeout", 32'h1, 32'h0);
			giveVerdict();
		end
	endtask
	// outputs quiet in reset, then the serial wait
	task automatic resetChk();
		int n;
		chk("valid in reset", 32'h0, rateValid);
		chk("ready in reset", 32'h0, serialReady);
		sys_rst = 1'h0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (serialReady !== 1'h1 && n < 100);
		chk("serial wait", WAITC, n);
	endtask
	// every interface form with and without the fuse
	task automatic modeChk();
		for (int m = 0; m < 8; m++) begin
			ifMode = m[1:0];
			multiDevFuse = m[2];
			repeat (2) @(negedge core_clk);
			chk("mode ok", m[1:0] != 2'h3, ifModeOk);
			chk("multi dev", m[2] && m[1:0] == 2'h0, multiDevActive);
		end
		ifMode = 2'h0;
		multiDevFuse = 1'h0;
	endtask
	// stages bypassed: words pass or saturate, temperature words round or saturate
	task automatic passChk();
		logic signed [23:0] ain [4] = '{24'sh123456, 24'sh800000, 24'sh123456, 24'shFF0000};
		logic signed [23:0] rex [4] = '{24'sh123456, 24'sh800000, 24'sh007FFF, 24'shFF8000};
		logic signed [15:0] tin [4] = '{16'sh7FFF, 16'sh8000, 16'sh7FFF, 16'sh8000};
		logic signed [11:0] tex [4] = '{12'sh07F, 12'shE00, 12'sh7FF, 12'sh800};
		rsf_tw_t            tw  [4] = '{TW_8, TW_10, TW_12, TW_12};
		for (int k = 0; k < 4; k++) begin
			cfg.wide24 = k < 2;
			cfg.tempW = tw[k];
			adcData = ain[k];
			tempData = tin[k];
			@(negedge core_clk);
			waitWord();
			chk("rate word", rex[k], rateData);
			chk("temp word", tex[k], tempOut);
		end
	endtask
	// spacing between words for grade and rate divider
	task automatic period(input logic j, input logic [2:0] odr, input int exp);
		int n;
		cfg.gradeJ = j;
		cfg.odrSel = odr;
		@(negedge core_clk);
		waitWord();
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rateValid !== 1'h1 && n < 20000);
		chk("word spacing", exp, n);
	endtask
	// receiver stalls two ticks: the held word stands and none is lost
	task automatic stallChk();
		int                 n0;
		logic signed [23:0] a;
		a = 24'sh000111;
		cfg.wide24 = 1'h1;
		adcData = a;
		@(negedge core_clk);
		waitWord();
		stall = 1'h1;
		adcData = 24'sh000222;
		n0 = i_rsf_rx_model.rxQ.size();
		repeat (2 * TICK_HL + 10) @(negedge core_clk);
		chk("held word", a, rateData);
		chk("held valid", 32'h1, rateValid);
		stall = 1'h0;
		repeat (4) @(negedge core_clk);
		chk("words kept", n0 + 2, i_rsf_rx_model.rxQ.size());
		chk("first kept", a, i_rsf_rx_model.rxQ[n0]);
	endtask
	// restart the chain from rest with a step on the input, take the first word
	task automatic stepWord(input rsf_cfg_t c, output logic signed [23:0] w);
		cfg = c;
		adcData = 24'sh010000;
		sys_rst = 1'h1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'h0;
		@(negedge core_clk);
		chk("valid after reset", 32'h0, rateValid);
		waitWord();
		w = rateData;
	endtask
	// low-pass, high-pass and notch stages, each from rest with a step input
	task automatic filtChk();
		rsf_cfg_t           c;
		logic signed [23:0] w2;
		logic signed [23:0] w4;
		logic signed [23:0] wLo;
		logic signed [23:0] h1;
		c = '0;
		c.wide24 = 1'h1;
		c.lpfEn = 1'h1;
		c.lpfCut = 4'hD;
		stepWord(c, w2);
		chk("lp step", 32'h1, w2 > 24'sh000000 && w2 < 24'sh010000);
		c.lpfOrder = 2'h2;
		stepWord(c, w4);
		chk("lp order", 32'h1, w4 < w2);
		c.lpfOrder = 2'h0;
		c.lpfCut = 4'h0;
		stepWord(c, wLo);
		chk("lp cutoff", 32'h1, wLo < w2);
		c = '0;
		c.wide24 = 1'h1;
		c.hpfEn = 1'h1;
		c.hpfCut = 3'h6;
		stepWord(c, h1);
		chk("hp step", 32'h1, h1 > 24'sh008000 && h1 <= 24'sh010000);
		// first word leaves only once the serial wait is over
		repeat (WAITC + 2) @(negedge core_clk);
		waitWord();
		chk("hp decay", 32'h1, rateData < h1);
		c.hpfEn = 1'h0;
		c.notchEn = 1'h1;
		stepWord(c, h1);
		repeat (WAITC + 2) @(negedge core_clk);
		repeat (NOTCH_D) begin
			@(negedge core_clk);
			waitWord();
		end
		chk("notch dc", 24'sh010000, rateData);
	endtask
	// main sequence
	initial begin
		repeat (5) @(negedge core_clk);
		resetChk();
		modeChk();
		passChk();
		period(1'h0, 3'h0, TICK_HL);
		period(1'h1, 3'h0, TICK_J);
		period(1'h0, 3'h1, 2 * TICK_HL);
		stallChk();
		filtChk();
		giveVerdict();
	end
endmodule

// *** dv/rsf_rx_model.sv ***
`timescale 1ns/10ps
// host side receiver of the rate word stream
module rsf_rx_model
	import rsf_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     stall,
	input  wire logic                     serialReady,
	input  wire logic signed [RATE_W-1:0] rateData,
	input  wire logic                     rateValid,
	output logic                          rateReady
);
	logic signed [RATE_W-1:0] rxQ[$];
	assign rateReady = serialReady && !stall;
	// collect every accepted word in order
	always @(posedge core_clk) begin
		if (rateValid === 1'h1 && rateReady) begin
			rxQ.push_back(rateData);
		end
	end
endmodule

// *** rtl/rsf_output_filter_chain.sv ***
`timescale 1ns/10ps
// How it works
// - rate words are two's complement, 16 or 24 bits wide as configured.
// - the base sample tick is 13.770 kHz for grades H and L and 14.160 kHz for grade J.
// - the output rate is the base rate divided by 1, 2, 4 ... 128 as configured.
// - the low-pass stage has order 2, 3 or 4 and six cutoff settings.
// - the high-pass stage is first order, can be bypassed, and has seven cutoffs.
// - the notch stage has one enable and a fixed per-unit centre frequency.
// - the rate output is raw or taken after the enabled low-pass, high-pass and notch stages in series.
// - temperature words are two's complement, 8, 10 or 12 bits as configured.
// - the host uses 4-wire SPI, 3-wire SPI or I2C and nothing else.
// - multi-device addressing works only in 4-wire SPI on fused units.
module rsf_output_filter_chain
	import rsf_pkg::*;
#(
	parameter int WAIT_CYCLES = WAIT_CYC,
	parameter int NOTCH_DLY   = NOTCH_D
) (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire rsf_cfg_t                 cfg,
	input  wire logic signed [ADC_W-1:0]  adcData,
	input  wire logic signed [TIN_W-1:0]  tempData,
	input  wire logic [1:0]               ifMode,
	input  wire logic                     multiDevFuse,
	input  wire logic                     rateReady,
	output logic signed [RATE_W-1:0]      rateData,
	output logic                          rateValid,
	output logic signed [TOUT_W-1:0]      tempOut,
	output logic                          serialReady,
	output logic                          ifModeOk,
	output logic                          multiDevActive
);
	typedef logic signed [ACC_W-1:0] acc_t;

	// saturate a wide value to w bits, sign-extended to 24
	function automatic logic signed [RATE_W-1:0] sat(input acc_t v, input int w);
		acc_t hi;
		acc_t lo;
		hi = (acc_t'(1) <<< (w - 1)) - acc_t'(1);
		lo = -(acc_t'(1) <<< (w - 1));
		if (v > hi) begin
			sat = hi[RATE_W-1:0];
		end else if (v < lo) begin
			sat = lo[RATE_W-1:0];
		end else begin
			sat = v[RATE_W-1:0];
		end
	endfunction

	// low-pass smoothing shift per cutoff index
	function automatic int lpShift(input logic [3:0] c);
		case (c)
			4'h0: lpShift = 8;
			4'h1, 4'h2: lpShift = 6;
			4'h3, 4'h4, 4'h5: lpShift = 5;
			4'h6, 4'h7, 4'h8: lpShift = 4;
			4'h9, 4'hA, 4'hB: lpShift = 3;
			default: lpShift = 2;
		endcase
	endfunction

	// high-pass tracking shift per cutoff index
	function automatic int hpShift(input logic [2:0] c);
		case (c)
			3'h0: hpShift = 18;
			3'h1: hpShift = 16;
			3'h2: hpShift = 14;
			3'h3: hpShift = 13;
			3'h4: hpShift = 11;
			3'h5: hpShift = 9;
			default: hpShift = 8;
		endcase
	endfunction

	logic [TICK_W-1:0]       tickCnt_r;
	logic                    tick_r;
	logic                    step;
	acc_t                    lpS_r [LP_MAX];
	acc_t                    lpNxt [LP_MAX];
	acc_t                    hpS_r;
	acc_t                    hpNxt;
	acc_t                    ntIn;
	acc_t                    filt;
	acc_t                    dly_r [NOTCH_DLY];
	logic [DEC_W-1:0]        decCnt_r;
	logic                    lastDec;
	logic                    push;
	logic                    pop;
	logic signed [RATE_W-1:0] wordIn;
	logic                    spV_r;
	logic signed [RATE_W-1:0] spD_r;
	rsf_st_t                 st_r;
	logic [31:0]             waitCnt_r;
	logic [3:0]              tShift;
	int                      tWidth;

	// base sample tick from the core clock
	// base rate select
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tickCnt_r <= '0;
			tick_r    <= 1'b0;
		end else if (tickCnt_r == '0) begin
			tickCnt_r <= cfg.gradeJ ? TICK_W'(TICK_J - 1) : TICK_W'(TICK_HL - 1);
			tick_r    <= 1'b1;
		end else begin
			tickCnt_r <= tickCnt_r - TICK_W'(1);
			tick_r    <= 1'b0;
		end
	end

	// a full buffer holds the chain so no queued word is overwritten
	assign step = tick_r && !spV_r;

	// filter chain for one sample
	always_comb begin
		acc_t v;
		int   ord;
		v   = acc_t'(adcData) <<< FRAC;
		ord = int'(cfg.lpfOrder) + LP_MIN;
		if (ord > LP_MAX) begin
			ord = LP_MAX;
		end
		for (int i = 0; i < LP_MAX; i++) begin
			lpNxt[i] = lpS_r[i] + ((v - lpS_r[i]) >>> lpShift(cfg.lpfCut));
			if (cfg.lpfEn && i < ord) begin
				v = lpNxt[i];
			end
		end
		hpNxt = hpS_r + ((v - hpS_r) >>> hpShift(cfg.hpfCut));
		if (cfg.hpfEn) begin
			v = v - hpNxt;
		end
		ntIn = v;
		if (cfg.notchEn) begin
			v = (v + dly_r[NOTCH_DLY-1]) >>> 1;
		end
		filt = v;
	end

	// filter state update
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < LP_MAX; i++) begin
				lpS_r[i] <= '0;
			end
			hpS_r <= '0;
		end else if (step) begin
			for (int i = 0; i < LP_MAX; i++) begin
				lpS_r[i] <= lpNxt[i];
			end
			hpS_r <= hpNxt;
		end
	end

	// notch delay line
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NOTCH_DLY; i++) begin
				dly_r[i] <= '0;
			end
		end else if (step) begin
			dly_r[0] <= ntIn;
			for (int i = 1; i < NOTCH_DLY; i++) begin
				dly_r[i] <= dly_r[i-1];
			end
		end
	end

	// decimation by a power of two
	assign lastDec = decCnt_r >= ((DEC_W'(1) << cfg.odrSel) - DEC_W'(1));
	assign push    = step && lastDec;
	assign pop     = rateValid && rateReady;
	assign wordIn  = sat(filt >>> FRAC, cfg.wide24 ? RATE_W : RATE_NARROW);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			decCnt_r <= '0;
		end else if (step) begin
			decCnt_r <= lastDec ? '0 : decCnt_r + DEC_W'(1);
		end
	end

	// two-entry output buffer: head drives the port, spare absorbs a stall
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rateValid <= 1'b0;
			rateData  <= '0;
			spV_r     <= 1'b0;
			spD_r     <= '0;
		end else if (pop || !rateValid) begin
			if (spV_r) begin
				rateValid <= 1'b1;
				rateData  <= spD_r;
				spV_r     <= push;
				spD_r     <= wordIn;
			end else begin
				rateValid <= push;
				rateData  <= push ? wordIn : rateData;
			end
		end else if (push) begin
			spV_r <= 1'b1;
			spD_r <= wordIn;
		end
	end

	// temperature width decode
	always_comb begin
		case (cfg.tempW)
			TW_8:    tWidth = T8;
			TW_10:   tWidth = T10;
			default: tWidth = T12;
		endcase
		tShift = 4'(TIN_W - tWidth);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tempOut <= '0;
		end else if (tick_r) begin
			tempOut <= TOUT_W'(sat((acc_t'(tempData)
				+ ((acc_t'(1) <<< tShift) >>> 1)) >>> tShift, tWidth));
		end
	end

	// power-up wait before the port answers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r        <= ST_WAIT;
			waitCnt_r   <= '0;
			serialReady <= 1'b0;
		end else begin
			case (st_r)
				ST_WAIT: begin
					if (waitCnt_r >= 32'(WAIT_CYCLES - 1)) begin
						st_r        <= ST_RUN;
						serialReady <= 1'b1;
					end else begin
						waitCnt_r <= waitCnt_r + 32'd1;
					end
				end
				ST_RUN: serialReady <= 1'b1;
				default: st_r <= ST_WAIT;
			endcase
		end
	end

	// serial form checks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ifModeOk       <= 1'b0;
			multiDevActive <= 1'b0;
		end else begin
			ifModeOk <= ifMode == IF_SPI4 || ifMode == IF_SPI3 || ifMode == IF_I2C;
			multiDevActive <= multiDevFuse && ifMode == IF_SPI4 && st_r == ST_RUN;
		end
	end

	property p_mdev;
		@(posedge core_clk) disable iff (sys_rst)
		multiDevActive |-> $past(ifMode) == IF_SPI4 && $past(multiDevFuse);
	endproperty
	a_mdev: assert property (p_mdev) else $error("multi-device active outside 4-wire");

	property p_narrow;
		@(posedge core_clk) disable iff (sys_rst)
		push && !cfg.wide24 |-> wordIn <= 24'sh007FFF && wordIn >= -24'sh008000;
	endproperty
	a_narrow: assert property (p_narrow) else $error("16-bit word out of range");

	property p_temp8;
		@(posedge core_clk) disable iff (sys_rst)
		tick_r && cfg.tempW == TW_8 |=> tempOut <= 12'sh07F && tempOut >= -12'sh080;
	endproperty
	a_temp8: assert property (p_temp8) else $error("8-bit temperature out of range");

	property p_hold;
		@(posedge core_clk) disable iff (sys_rst)
		rateValid && !rateReady |=> rateValid && $stable(rateData);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word changed");

	property p_tick;
		@(posedge core_clk) disable iff (sys_rst)
		tick_r |=> !tick_r [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("sample tick too fast");

	property p_decim;
		@(posedge core_clk) disable iff (sys_rst)
		step && cfg.odrSel == 3'h0 |-> push;
	endproperty
	a_decim: assert property (p_decim) else $error("full rate dropped a sample");

	property p_pass;
		@(posedge core_clk) disable iff (sys_rst)
		push && cfg.wide24 && !cfg.lpfEn && !cfg.hpfEn && !cfg.notchEn |-> wordIn == adcData;
	endproperty
	a_pass: assert property (p_pass) else $error("bypassed chain altered data");

	property p_wait;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(serialReady) |-> waitCnt_r == 32'(WAIT_CYCLES - 1);
	endproperty
	a_wait: assert property (p_wait) else $error("serial ready before wait");

	property p_ifok;
		@(posedge core_clk) disable iff (sys_rst)
		ifModeOk |-> $past(ifMode) != 2'h3;
	endproperty
	a_ifok: assert property (p_ifok) else $error("unknown serial form accepted");
endmodule
